// ### logic/ifeu_pkg.sv
package ifeu_pkg;

    // Clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int WAKE_BASE_MS = 16;
    localparam int WAKE_BASE_CYCLES = WAKE_BASE_MS * (CLK_HZ / 1000);
    localparam int WAKE_CNT_W = 21;
    localparam int TOUCH_LAG_NS = 3000;
    localparam int TOUCH_LAG_CYCLES = TOUCH_LAG_NS / (1_000_000_000 / CLK_HZ);

    // Bus geometry
    localparam int WB_ADR_W = 12;
    localparam int IDX_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 10'h00b;
    localparam logic [IDX_W-1:0] IDX_IRQ_PENDING = 10'h00c;
    localparam logic [IDX_W-1:0] IDX_TOUCH_CTRL = 10'h01f;
    localparam logic [IDX_W-1:0] IDX_OPTION = 10'h081;

    // Enable and pending bit positions (same in both registers)
    localparam int SRC_CONVERTER = 7;
    localparam int SRC_TIMEBASE = 6;
    localparam int SRC_TIMER_B = 5;
    localparam int SRC_TIMER_A = 4;
    localparam int SRC_WAKEUP = 3;
    localparam int SRC_PIN_C = 2;
    localparam int SRC_PIN_B = 1;
    localparam int SRC_PIN_A = 0;

    // Touch control/status fields
    localparam int TK_FLAG_BIT = 7;
    localparam int TK_EN_BIT = 6;
    localparam int TK_START_BIT = 5;
    localparam int TK_DONE_BIT = 4;
    localparam int TK_CHS_LSB = 0;

    // Option fields
    localparam int OPT_AUTO_SAVE_BIT = 7;
    localparam int OPT_PIN_A_POL_BIT = 6;
    localparam int OPT_PIN_B_POL_BIT = 5;
    localparam int OPT_PIN_A_SEL_BIT = 4;
    localparam int OPT_WDT_LSB = 2;
    localparam int OPT_WAKE_LSB = 0;

    // Status bits left alone by the automatic restore
    localparam logic [7:0] STAT_KEEP_MASK = 8'h18;

    // Reset values
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_PENDING = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h0f;

    // Synchroniser lanes
    localparam int PIN_A0 = 0;
    localparam int PIN_A1 = 1;
    localparam int PIN_B = 2;
    localparam int PIN_C = 3;

    typedef enum {REG_NONE, REG_ENABLE, REG_PENDING, REG_TOUCH, REG_OPTION} ifeu_reg_t;

    typedef struct packed {
        logic [7:0] en;
        logic [7:0] flag;
        logic tk_flag;
        logic tk_en;
        logic tk_start;
        logic tk_busy;
        logic [3:0] tk_chs;
        logic [7:0] opt;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [2:0] pin_prev;
        logic [7:0] saved_status;
        logic restore_valid;
        logic [7:0] restore_data;
        logic ack;
        logic [7:0] rdata;
    } ifeu_state_t;

    localparam ifeu_state_t ST_RESET = '{
        en: RST_IRQ_ENABLE,
        flag: RST_IRQ_PENDING,
        tk_flag: 1'b0,
        tk_en: 1'b0,
        tk_start: 1'b0,
        tk_busy: 1'b0,
        tk_chs: 4'h0,
        opt: RST_OPTION,
        wake_cnt: '0,
        pin_s1: 4'hf,
        pin_s2: 4'hf,
        pin_prev: 3'h7,
        saved_status: 8'h00,
        restore_valid: 1'b0,
        restore_data: 8'h00,
        ack: 1'b0,
        rdata: 8'h00
    };

endpackage

// ### logic/ifeu_top.sv
`timescale 1ns/10ps
module ifeu_top
    import ifeu_pkg::*;
#(
    parameter int WAKE_BASE = WAKE_BASE_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Peripheral event pulses
    input wire logic converter_done_i,
    input wire logic timebase_ovf_i,
    input wire logic timer_b_ovf_i,
    input wire logic timer_a_ovf_i,
    input wire logic touch_conv_end_i,
    // External interrupt pins
    input wire logic ext_pin_a_dflt_i,
    input wire logic ext_pin_a_alt_i,
    input wire logic ext_pin_b_i,
    input wire logic ext_pin_c_i,
    // Processor core
    input wire logic global_irq_en_i,
    input wire logic irq_enter_i,
    input wire logic irq_return_i,
    input wire logic [7:0] status_i,
    output logic irq_req_o,
    output logic [8:0] irq_src_o,
    output logic status_restore_o,
    output logic [7:0] status_restore_data_o,
    // Touch engine control and watchdog prescaler
    output logic touch_conv_start_o,
    output logic [3:0] touch_channel_o,
    output logic [7:0] wdt_psc_o
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic ifeu_reg_t decode(input logic [WB_ADR_W-1:0] adr);
        logic [IDX_W-1:0] idx;
        idx = adr[WB_ADR_W-1:2];
        unique case (idx)
            IDX_IRQ_ENABLE: decode = REG_ENABLE;
            IDX_IRQ_PENDING: decode = REG_PENDING;
            IDX_TOUCH_CTRL: decode = REG_TOUCH;
            IDX_OPTION: decode = REG_OPTION;
            default: decode = REG_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    ifeu_state_t st_r;
    ifeu_state_t st_nxt;

    logic bus_req;
    logic wr_commit;
    ifeu_reg_t reg_sel;
    logic [7:0] wdat;
    logic pin_a_now;
    logic [2:0] pin_now;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [7:0] set_ev;
    logic [7:0] clr_mask;
    logic [WAKE_CNT_W-1:0] wake_limit;
    logic wake_expire;
    logic tk_start_wr;
    logic [7:0] touch_rd;
    logic [8:0] req_vec;

    assign bus_req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where ack is seen high
    assign wr_commit = bus_req & wb_we_i & st_r.ack & wb_sel_i[0];
    assign reg_sel = decode(wb_adr_i);
    assign wdat = wb_dat_i[7:0];

    // Pin A source chosen after synchronisation
    assign pin_a_now = st_r.opt[OPT_PIN_A_SEL_BIT] ? st_r.pin_s2[PIN_A1]
                                                  : st_r.pin_s2[PIN_A0];
    assign pin_now = {st_r.pin_s2[PIN_C], st_r.pin_s2[PIN_B], pin_a_now};
    assign rise = pin_now & ~st_r.pin_prev;
    assign fall = ~pin_now & st_r.pin_prev;

    assign wake_limit = WAKE_CNT_W'(WAKE_BASE) << st_r.opt[OPT_WAKE_LSB +: 2];
    assign wake_expire = st_r.en[SRC_WAKEUP] && (st_r.wake_cnt >= wake_limit - 1'b1);

    always_comb begin
        set_ev = 8'h00;
        set_ev[SRC_CONVERTER] = converter_done_i;
        set_ev[SRC_TIMEBASE] = timebase_ovf_i;
        set_ev[SRC_TIMER_B] = timer_b_ovf_i;
        set_ev[SRC_TIMER_A] = timer_a_ovf_i;
        set_ev[SRC_WAKEUP] = wake_expire;
        set_ev[SRC_PIN_C] = fall[2];
        set_ev[SRC_PIN_B] = st_r.opt[OPT_PIN_B_POL_BIT] ? rise[1] : fall[1];
        set_ev[SRC_PIN_A] = st_r.opt[OPT_PIN_A_POL_BIT] ? rise[0] : fall[0];
    end

    // Zero bits of a pending write clear, ones leave alone
    assign clr_mask = (wr_commit && reg_sel == REG_PENDING) ? ~wdat : 8'h00;
    assign tk_start_wr = wr_commit && reg_sel == REG_TOUCH && wdat[TK_START_BIT];

    always_comb begin
        touch_rd = 8'h00;
        touch_rd[TK_FLAG_BIT] = st_r.tk_flag;
        touch_rd[TK_EN_BIT] = st_r.tk_en;
        touch_rd[TK_START_BIT] = st_r.tk_start;
        touch_rd[TK_DONE_BIT] = ~st_r.tk_busy;
        touch_rd[TK_CHS_LSB +: 4] = st_r.tk_chs;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;

        // Two-stage synchroniser, then edge history
        st_nxt.pin_s1 = {ext_pin_c_i, ext_pin_b_i, ext_pin_a_alt_i, ext_pin_a_dflt_i};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_prev = pin_now;

        // Bus answer: ack one cycle after the request, then drop
        st_nxt.ack = bus_req & ~st_r.ack;
        if (bus_req && !st_r.ack) begin
            unique case (reg_sel)
                REG_ENABLE: st_nxt.rdata = st_r.en;
                REG_PENDING: st_nxt.rdata = st_r.flag;
                REG_TOUCH: st_nxt.rdata = touch_rd;
                REG_OPTION: st_nxt.rdata = st_r.opt;
                REG_NONE: st_nxt.rdata = 8'h00;
            endcase
        end

        // Register writes
        if (wr_commit) begin
            unique case (reg_sel)
                REG_ENABLE: st_nxt.en = wdat;
                REG_OPTION: st_nxt.opt = wdat;
                REG_TOUCH: begin
                    st_nxt.tk_en = wdat[TK_EN_BIT];
                    st_nxt.tk_start = wdat[TK_START_BIT];
                    st_nxt.tk_chs = wdat[TK_CHS_LSB +: 4];
                end
                REG_PENDING, REG_NONE: begin
                end
            endcase
        end

        // Event set wins over a simultaneous software clear
        st_nxt.flag = (st_r.flag & ~clr_mask) | set_ev;

        // Wake-up timer held clear while its enable is low
        if (!st_r.en[SRC_WAKEUP] || wake_expire) begin
            st_nxt.wake_cnt = '0;
        end else begin
            st_nxt.wake_cnt = st_r.wake_cnt + 1'b1;
        end

        // Touch conversion handshake
        if (tk_start_wr) begin
            st_nxt.tk_busy = 1'b1;
        end else if (touch_conv_end_i) begin
            st_nxt.tk_busy = 1'b0;
            st_nxt.tk_start = 1'b0;
        end
        if (touch_conv_end_i) begin
            st_nxt.tk_flag = 1'b1;
        end else if (tk_start_wr) begin
            st_nxt.tk_flag = 1'b0;
        end else if (wr_commit && reg_sel == REG_TOUCH && !wdat[TK_FLAG_BIT]) begin
            st_nxt.tk_flag = 1'b0;
        end

        // Automatic status save and restore
        st_nxt.restore_valid = 1'b0;
        if (st_r.opt[OPT_AUTO_SAVE_BIT]) begin
            if (irq_enter_i) begin
                st_nxt.saved_status = status_i;
            end
            if (irq_return_i) begin
                st_nxt.restore_valid = 1'b1;
                // Timeout and sleep flags keep their live values
                st_nxt.restore_data = (st_r.saved_status & ~STAT_KEEP_MASK)
                                    | (status_i & STAT_KEEP_MASK);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign req_vec = {st_r.tk_flag & st_r.tk_en, st_r.flag & st_r.en};
    assign irq_src_o = global_irq_en_i ? req_vec : 9'h000;
    assign irq_req_o = |irq_src_o;
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = {24'h000000, st_r.rdata};
    assign status_restore_o = st_r.restore_valid;
    assign status_restore_data_o = st_r.restore_data;
    assign touch_conv_start_o = st_r.tk_start;
    assign touch_channel_o = st_r.tk_chs;
    assign wdt_psc_o = {6'h00, st_r.opt[OPT_WDT_LSB +: 2]};

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_conv_flag;
        converter_done_i |=> st_r.flag[SRC_CONVERTER];
    endproperty
    a_conv_flag: assert property (p_conv_flag) else $error("converter flag not set");

    property p_tb_flag;
        timebase_ovf_i |=> st_r.flag[SRC_TIMEBASE];
    endproperty
    a_tb_flag: assert property (p_tb_flag) else $error("time-base flag not set");

    property p_tmb_flag;
        timer_b_ovf_i |=> st_r.flag[SRC_TIMER_B];
    endproperty
    a_tmb_flag: assert property (p_tmb_flag) else $error("timer B flag not set");

    property p_tma_flag;
        timer_a_ovf_i |=> st_r.flag[SRC_TIMER_A];
    endproperty
    a_tma_flag: assert property (p_tma_flag) else $error("timer A flag not set");

    property p_wake_hold;
        !st_r.en[SRC_WAKEUP] |=> st_r.wake_cnt == '0 && !$rose(st_r.flag[SRC_WAKEUP]);
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake-up timer ran disabled");

    property p_pin_c_fall;
        $fell(st_r.pin_s2[PIN_C]) |=> st_r.flag[SRC_PIN_C];
    endproperty
    a_pin_c_fall: assert property (p_pin_c_fall) else $error("pin C fall missed");

    property p_pend_clear;
        wr_commit && reg_sel == REG_PENDING && !wdat[SRC_CONVERTER] && !converter_done_i
            |=> !st_r.flag[SRC_CONVERTER];
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("write 0 did not clear");

    property p_touch_end;
        touch_conv_end_i && !tk_start_wr
            |=> st_r.tk_flag && !st_r.tk_start && touch_rd[TK_DONE_BIT];
    endproperty
    a_touch_end: assert property (p_touch_end) else $error("touch end handling wrong");

    property p_global_gate;
        irq_req_o |-> global_irq_en_i
            && ((st_r.flag & st_r.en) != 8'h00 || st_r.tk_flag && st_r.tk_en);
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("request without cause");

    property p_restore;
        irq_return_i && st_r.opt[OPT_AUTO_SAVE_BIT]
            |=> status_restore_o
            && (status_restore_data_o & STAT_KEEP_MASK) == ($past(status_i) & STAT_KEEP_MASK);
    endproperty
    a_restore: assert property (p_restore) else $error("status restore wrong");

    property p_enable_write;
        wr_commit && reg_sel == REG_ENABLE |=> st_r.en == $past(wdat);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_wake_flag;
        wake_expire |=> st_r.flag[SRC_WAKEUP] && st_r.wake_cnt == '0;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake-up flag not set");

    property p_pb_rise;
        st_r.opt[OPT_PIN_B_POL_BIT] && $rose(st_r.pin_s2[PIN_B]) |=> st_r.flag[SRC_PIN_B];
    endproperty
    a_pb_rise: assert property (p_pb_rise) else $error("pin B rise missed");

    property p_pb_fall;
        !st_r.opt[OPT_PIN_B_POL_BIT] && $fell(st_r.pin_s2[PIN_B]) |=> st_r.flag[SRC_PIN_B];
    endproperty
    a_pb_fall: assert property (p_pb_fall) else $error("pin B fall missed");

    // Only a steady select, since a select change alone can make an edge
    property p_pa_fall;
        !st_r.opt[OPT_PIN_A_SEL_BIT] && $stable(st_r.opt[OPT_PIN_A_SEL_BIT])
            && !st_r.opt[OPT_PIN_A_POL_BIT] && $fell(st_r.pin_s2[PIN_A0])
            |=> st_r.flag[SRC_PIN_A];
    endproperty
    a_pa_fall: assert property (p_pa_fall) else $error("pin A fall missed");

    property p_pa_rise;
        st_r.opt[OPT_PIN_A_SEL_BIT] && $stable(st_r.opt[OPT_PIN_A_SEL_BIT])
            && st_r.opt[OPT_PIN_A_POL_BIT] && $rose(st_r.pin_s2[PIN_A1])
            |=> st_r.flag[SRC_PIN_A];
    endproperty
    a_pa_rise: assert property (p_pa_rise) else $error("alternate pin A missed");

    property p_src_mask;
        (irq_src_o[7:0] & ~st_r.en) == 8'h00;
    endproperty
    a_src_mask: assert property (p_src_mask) else $error("masked source requested");

    property p_touch_mask;
        !st_r.tk_en |-> !irq_src_o[8];
    endproperty
    a_touch_mask: assert property (p_touch_mask) else $error("touch request not masked");

    property p_pin_c_once;
        wr_commit && reg_sel == REG_PENDING && !wdat[SRC_PIN_C]
            && $stable(st_r.pin_s2[PIN_C]) |=> !st_r.flag[SRC_PIN_C];
    endproperty
    a_pin_c_once: assert property (p_pin_c_once) else $error("level set flag again");

    property p_touch_start;
        tk_start_wr && !touch_conv_end_i |=> !st_r.tk_flag;
    endproperty
    a_touch_start: assert property (p_touch_start) else $error("start kept touch flag");

    property p_touch_busy;
        tk_start_wr |=> st_r.tk_start && !touch_rd[TK_DONE_BIT];
    endproperty
    a_touch_busy: assert property (p_touch_busy) else $error("done not low on start");

    property p_touch_stop;
        wr_commit && reg_sel == REG_TOUCH && !wdat[TK_START_BIT] |=> !touch_conv_start_o;
    endproperty
    a_touch_stop: assert property (p_touch_stop) else $error("start not cleared");

    c_irq_raised: cover property (irq_req_o ##1 wr_commit);
    c_touch_cycle: cover property (tk_start_wr ##[1:50] touch_conv_end_i);
    c_wake_expire: cover property (wake_expire);
    c_pin_a_rise: cover property (st_r.opt[OPT_PIN_A_POL_BIT] && rise[0]);

endmodule

// ### tb/ifeu_core_model.sv
`timescale 1ns/10ps
module ifeu_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic gie_cmd_i,
    input wire logic svc_en_i,
    input wire logic [3:0] svc_len_i,
    // Interrupt unit side
    input wire logic irq_req_i,
    output logic global_irq_en_o,
    output logic irq_enter_o,
    output logic irq_return_o,
    output logic [7:0] status_o
);
    logic busy_r;
    logic [3:0] cnt_r;
    // Entry masks further requests until return
    assign global_irq_en_o = gie_cmd_i & ~busy_r;
    // Handler rewrites status through the return cycle; the entry value comes back after it, with no restore needed
    assign status_o = ((busy_r && !irq_enter_o) || irq_return_o) ? 8'h00 : 8'hff;
    always_ff @(posedge clk_i) begin
        irq_enter_o <= 1'b0;
        irq_return_o <= 1'b0;
        if (rst_i) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
        end else if (!busy_r && svc_en_i && irq_req_i && global_irq_en_o) begin
            busy_r <= 1'b1;
            irq_enter_o <= 1'b1;
            cnt_r <= svc_len_i;
        end else if (busy_r) begin
            if (cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                irq_return_o <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import ifeu_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0, q;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_req_o, restore_o, global_irq_en, enter, ret;
    logic [8:0] irq_src_o;
    logic tk_start_o;
    logic [3:0] tk_chan;
    logic [7:0] wdt_o;
    logic [7:0] rdata, status, last_rst;
    logic [4:0] ev = 5'h00;
    logic [3:0] pin = 4'hf;
    logic gie_cmd = 1'b0, svc_en = 1'b0;
    logic [3:0] svc_len = 4'h3;
    int miscompares = 0, check_count = 0, restore_cnt = 0;
    localparam logic [7:0] EV_IN[5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h09};
    localparam logic [7:0] EV_EXP[5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h90};

    always #50 clk_i = ~clk_i;

    ifeu_top #(.WAKE_BASE(20)) ifeu_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .converter_done_i(ev[3]), .timebase_ovf_i(ev[2]),
        .timer_b_ovf_i(ev[1]), .timer_a_ovf_i(ev[0]), .touch_conv_end_i(ev[4]),
        .ext_pin_a_dflt_i(pin[3]), .ext_pin_a_alt_i(pin[2]), .ext_pin_b_i(pin[1]),
        .ext_pin_c_i(pin[0]), .global_irq_en_i(global_irq_en), .irq_enter_i(enter),
        .irq_return_i(ret), .status_i(status), .irq_req_o(irq_req_o),
        .irq_src_o(irq_src_o), .status_restore_o(restore_o),
        .status_restore_data_o(rdata), .touch_conv_start_o(tk_start_o),
        .touch_channel_o(tk_chan), .wdt_psc_o(wdt_o));

    ifeu_core_model ifeu_core_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .gie_cmd_i(gie_cmd), .svc_en_i(svc_en),
        .svc_len_i(svc_len), .irq_req_i(irq_req_o), .global_irq_en_o(global_irq_en),
        .irq_enter_o(enter), .irq_return_o(ret), .status_o(status));

    always @(posedge clk_i) begin
        if (restore_o === 1'b1) begin
            restore_cnt++;
            last_rst = rdata;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat_w <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            $display("[FAIL] t=%0t ack timeout got=%h exp=%h", $time, wb_ack_o, 1'b1);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'hf);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, 4'hf);
        chk(q, {24'h0, exp});
    endtask

    task automatic pulse(input logic [4:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 5'h00;
    endtask

    task automatic pins(input logic [3:0] p);
        @(posedge clk_i);
        pin <= p;
        repeat (6) @(posedge clk_i);
    endtask

    task wrap_up;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(IDX_IRQ_ENABLE, 8'h00);
        rd(IDX_TOUCH_CTRL, 8'h10);
        rd(IDX_OPTION, 8'h0f);
        chk(32'(wdt_o), 32'h3);
        rd(10'h00d, 8'h00);
        for (int i = 0; i < 5; i++) begin
            pulse(EV_IN[i][4:0]);
            rd(IDX_IRQ_PENDING, EV_EXP[i]);
            wr(IDX_IRQ_PENDING, 8'h00);
            rd(IDX_IRQ_PENDING, 8'h00);
        end
        pulse(5'h0c);
        wr(IDX_IRQ_PENDING, 8'h7f);
        rd(IDX_IRQ_PENDING, 8'h40);
        wr(IDX_IRQ_PENDING, 8'h00);
        wb(1'b1, IDX_IRQ_ENABLE, 8'hff, 4'he);
        rd(IDX_IRQ_ENABLE, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h10);
        pulse(5'h01);
        @(negedge clk_i);
        chk(32'(irq_req_o), 32'h0);
        @(posedge clk_i);
        gie_cmd <= 1'b1;
        @(negedge clk_i);
        chk(32'({irq_req_o, irq_src_o}), 32'h210);
        wr(IDX_IRQ_ENABLE, 8'h00);
        @(negedge clk_i);
        chk(32'(irq_req_o), 32'h0);
        rd(IDX_IRQ_PENDING, 8'h10);
        // Service with automatic save: handler zeroes status meanwhile
        wr(IDX_OPTION, 8'h8f);
        wr(IDX_IRQ_ENABLE, 8'h10);
        svc_en <= 1'b1;
        repeat (12) @(posedge clk_i);
        svc_en <= 1'b0;
        gie_cmd <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(32'(last_rst), 32'he7);
        chk(32'(restore_cnt > 0), 32'h1);
        wr(IDX_IRQ_ENABLE, 8'h00);
        wr(IDX_OPTION, 8'h0f);
        wr(IDX_IRQ_PENDING, 8'h00);
        pins(4'he);
        rd(IDX_IRQ_PENDING, 8'h04);
        wr(IDX_IRQ_PENDING, 8'h00);
        pins(4'he);
        rd(IDX_IRQ_PENDING, 8'h00);
        pins(4'hf);
        wr(IDX_OPTION, 8'h7f);
        repeat (6) @(posedge clk_i);
        wr(IDX_IRQ_PENDING, 8'h00);
        pins(4'h1);
        rd(IDX_IRQ_PENDING, 8'h00);
        pins(4'h7);
        rd(IDX_IRQ_PENDING, 8'h03);
        wr(IDX_IRQ_PENDING, 8'h00);
        // Select back to the low default pin: one falling edge on pin A
        wr(IDX_OPTION, 8'h00);
        rd(IDX_IRQ_PENDING, 8'h01);
        chk(32'(wdt_o), 32'h0);
        wr(IDX_IRQ_PENDING, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h08);
        repeat (30) @(posedge clk_i);
        rd(IDX_IRQ_PENDING, 8'h08);
        wr(IDX_IRQ_ENABLE, 8'h00);
        wr(IDX_IRQ_PENDING, 8'h00);
        repeat (40) @(posedge clk_i);
        rd(IDX_IRQ_PENDING, 8'h00);
        wr(IDX_OPTION, 8'h0f);
        wr(IDX_IRQ_ENABLE, 8'h08);
        repeat (100) @(posedge clk_i);
        rd(IDX_IRQ_PENDING, 8'h00);
        repeat (80) @(posedge clk_i);
        rd(IDX_IRQ_PENDING, 8'h08);
        wr(IDX_IRQ_ENABLE, 8'h00);
        wr(IDX_IRQ_PENDING, 8'h00);
        pins(4'hf);
        pins(4'h5);
        rd(IDX_IRQ_PENDING, 8'h03);
        wr(IDX_TOUCH_CTRL, 8'h20);
        @(negedge clk_i);
        chk(32'({tk_start_o, tk_chan}), 32'h10);
        rd(IDX_TOUCH_CTRL, 8'h20);
        pulse(5'h10);
        rd(IDX_TOUCH_CTRL, 8'h90);
        wr(IDX_TOUCH_CTRL, 8'hc3);
        gie_cmd <= 1'b1;
        @(negedge clk_i);
        chk(32'(irq_src_o), 32'h100);
        chk(32'({tk_start_o, tk_chan}), 32'h03);
        wr(IDX_TOUCH_CTRL, 8'h60);
        wr(IDX_TOUCH_CTRL, 8'h40);
        rd(IDX_TOUCH_CTRL, 8'h40);
        pulse(5'h10);
        rd(IDX_TOUCH_CTRL, 8'hd0);
        wrap_up();
    end
endmodule
